// ==== design/prw_map.svh ====
`ifndef PRW_MAP_SVH
`define PRW_MAP_SVH
// ==========================================================
// address map
`define PRW_BASE_BLOCKING    16'h0200
`define PRW_BASE_NONBLOCKING 16'h0300
`define PRW_BASE_MASK        16'hFFF0
`define PRW_OFF_CTL          4'h0
`define PRW_OFF_SR           4'h2
// ==========================================================
// control field positions
`define PRW_CTL_TIEM   15
`define PRW_CTL_UNDERVOLT_IRQ_ENABLE_MASK  14
`define PRW_CTL_SRM    13
`define PRW_CTL_PFM_HI 11
`define PRW_CTL_PFM_LO 10
`define PRW_CTL_OMM_HI 9
`define PRW_CTL_OMM_LO 8
`define PRW_CTL_TIE    7
`define PRW_CTL_UNDERVOLT_IRQ_ENABLE   6
`define PRW_CTL_SRC    5
`define PRW_CTL_PF_HI  3
`define PRW_CTL_PF_LO  2
`define PRW_CTL_OM_HI  1
`define PRW_CTL_OM_LO  0
// ==========================================================
// status field positions (upper byte of the word)
`define PRW_SR_LSB     8
`define PRW_SR_HTF     7
`define PRW_SR_UVF     6
`define PRW_SR_SOFT    5
`define PRW_SR_WDOG    4
`define PRW_SR_HIRAIL  3
`define PRW_SR_LORAIL  2
`define PRW_SR_LTC     1
`define PRW_SR_LPW     0
// ==========================================================
// reset values and timing
`define PRW_CTL_RST    16'h0000
`define PRW_SR_RST     8'h0C
`define PRW_MASK_ALL   2'h3
`define PRW_SRST_CYC   2'h2
`endif

// ==== design/prw_pkg.sv ====
package prw_pkg;
  typedef enum logic [1:0] {
    PRW_MODE_NORMAL = 2'b00,
    PRW_MODE_STOP   = 2'b01,
    PRW_MODE_SLEEP  = 2'b10,
    PRW_MODE_CRANK  = 2'b11
  } prw_mode_t;
endpackage : prw_pkg

// ==== design/prw_flag.sv ====
// ==========================================================
// sticky flag, set wins over clear
module prw_flag #(
  parameter logic RST_VAL = 1'b0
) (
  input  wire logic core_clk,
  input  wire logic rst,
  input  wire logic set,
  input  wire logic clr,
  output logic      flag_q
);
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      flag_q <= RST_VAL;
    end else if (set) begin
      flag_q <= 1'b1;
    end else if (clr) begin
      flag_q <= 1'b0;
    end
  end
endmodule : prw_flag

// ==== design/prw_regs.sv ====
`include "prw_map.svh"

// Functional notes
// - temp and undervolt irq enables change only with their mask bit set.
// - soft reset command acts only with its mask bit written as one.
// - prescale factor updates only when its mask field is 11.
// - operating mode updates only when its mask field is 11.
// - temp irq enable is inverted, zero enables the interrupt.
// - undervolt irq enable is inverted, zero enables the interrupt.
// - soft reset is write-only, resets die logic and drives reset out.
// - prescale code 00,01,10,11 gives factor 1,2,4,8.
// - mode code 00 normal, 01 stop, 10 sleep.
// - mode code 11 is cranking if enabled, else stop.
// - registers decode at base 0x0200 blocking and 0x300 non-blocking.
// - high temp flag set by temp warning or thermal shutdown reset.
// - temp/undervolt flags live; write one clears only when condition gone.
// - undervolt flag set by supply undervolt warning.
// - soft and watchdog reset cause flags set on reset, write one clears.
// - high-rail reset sets high flag; low-rail reset sets both flags.
// - low-rail flag set at power-on low-rail reset, write one clears.
// - lifetime counter wake flag set on overflow wake, write one clears.
// - low power wake flag set on low power wake, write one clears.
module prw_regs
  import prw_pkg::*;
(
  input  wire logic        core_clk,
  input  wire logic        rst,
  input  wire logic [15:0] reg_addr,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  input  wire logic [15:0] reg_wdata,
  output logic      [15:0] reg_rdata_q,
  input  wire logic        crank_enable,
  input  wire logic        temp_warning,
  input  wire logic        thermal_shutdown_reset,
  input  wire logic        undervolt_warning,
  input  wire logic        watchdog_reset_evt,
  input  wire logic        high_rail_reset_evt,
  input  wire logic        low_rail_reset_evt,
  input  wire logic        lifetime_wake_evt,
  input  wire logic        low_power_wake_evt,
  output logic      [3:0]  prescale_factor_q,
  output prw_mode_t        op_mode_q,
  output logic             high_temp_interrupt_q,
  output logic             undervolt_interrupt_q,
  output logic             temp_irq_clear_q,
  output logic             undervolt_irq_clear_q,
  output logic             die_reset_q,
  output logic             ext_reset_n_q
);
  // ========================================================
  // decode functions
  function automatic logic [3:0] pf_decode(input logic [1:0] code);
    pf_decode = 4'h1 << code;
  endfunction : pf_decode

  function automatic prw_mode_t mode_decode(input logic [1:0] code,
                                            input logic       crank);
    case (code)
      2'b00:   mode_decode = PRW_MODE_NORMAL;
      2'b01:   mode_decode = PRW_MODE_STOP;
      2'b10:   mode_decode = PRW_MODE_SLEEP;
      2'b11:   mode_decode = crank ? PRW_MODE_CRANK
                                   : PRW_MODE_STOP;
      default: mode_decode = PRW_MODE_NORMAL;
    endcase
  endfunction : mode_decode

  // ========================================================
  // address decode
  logic        tie_q;
  logic        undervolt_irq_enable_q;
  logic [1:0]  pf_q;
  logic [1:0]  om_q;
  logic [1:0]  srst_cnt_q;
  logic [1:0]  srst_cnt_d;
  logic [7:0]  sr_q;
  logic [7:0]  sr_set;
  logic [7:0]  sr_clr;

  localparam logic [7:0] SR_RST = `PRW_SR_RST;

  wire         hit_blk = (reg_addr & `PRW_BASE_MASK) ==
                         `PRW_BASE_BLOCKING;
  wire         hit_nb  = (reg_addr & `PRW_BASE_MASK) ==
                         `PRW_BASE_NONBLOCKING;
  wire         hit     = hit_blk | hit_nb;
  wire [3:0]   off     = reg_addr[3:0];
  wire         srst_on = srst_cnt_q != 2'h0;
  wire         wr_ctl  = reg_wr & hit & (off == `PRW_OFF_CTL) & ~srst_on;
  wire         wr_sr   = reg_wr & hit & (off == `PRW_OFF_SR);
  wire [7:0]   w1c     = wr_sr ? reg_wdata[15:`PRW_SR_LSB] : 8'h00;

  wire wr_tie  = wr_ctl & reg_wdata[`PRW_CTL_TIEM];
  wire wr_undervolt_irq_enable = wr_ctl & reg_wdata[`PRW_CTL_UNDERVOLT_IRQ_ENABLE_MASK];
  wire wr_pf   = wr_ctl & (reg_wdata[`PRW_CTL_PFM_HI:`PRW_CTL_PFM_LO]
                 == `PRW_MASK_ALL);
  wire wr_om   = wr_ctl & (reg_wdata[`PRW_CTL_OMM_HI:`PRW_CTL_OMM_LO]
                 == `PRW_MASK_ALL);
  wire srst_go = wr_ctl & reg_wdata[`PRW_CTL_SRM]
                 & reg_wdata[`PRW_CTL_SRC];

  wire temp_clr = w1c[`PRW_SR_HTF] & ~temp_warning;
  wire uv_clr   = w1c[`PRW_SR_UVF] & ~undervolt_warning;

  wire [15:0] ctl_rd = {8'h00, tie_q, undervolt_irq_enable_q, 2'b00,
                        pf_q, om_q};
  wire [15:0] rd_mux = ~hit ? 16'h0000 :
                       (off == `PRW_OFF_CTL) ? ctl_rd :
                       (off == `PRW_OFF_SR)  ? {sr_q, 8'h00} : 16'h0000;

  assign srst_cnt_d = srst_go ? `PRW_SRST_CYC :
                      srst_on ? srst_cnt_q - 2'h1 : 2'h0;

  // ========================================================
  // status flags
  assign sr_set = {temp_warning | thermal_shutdown_reset,
                   undervolt_warning,
                   srst_go, watchdog_reset_evt,
                   high_rail_reset_evt | low_rail_reset_evt,
                   low_rail_reset_evt,
                   lifetime_wake_evt,
                   low_power_wake_evt};
  assign sr_clr = {temp_clr, uv_clr, w1c[5:0]};

  for (genvar i = 0; i < 8; i++) begin : g_flag
    prw_flag #(
      .RST_VAL (SR_RST[i])
    ) u_flag (
      .core_clk (core_clk),
      .rst      (rst),
      .set      (sr_set[i]),
      .clr      (sr_clr[i]),
      .flag_q   (sr_q[i])
    );
  end

  // ========================================================
  // control register, cleared by soft reset
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      tie_q  <= 1'b0;
      undervolt_irq_enable_q <= 1'b0;
      pf_q   <= 2'h0;
      om_q   <= 2'h0;
    end else if (srst_on) begin
      tie_q  <= 1'b0;
      undervolt_irq_enable_q <= 1'b0;
      pf_q   <= 2'h0;
      om_q   <= 2'h0;
    end else begin
      if (wr_tie)  tie_q  <= reg_wdata[`PRW_CTL_TIE];
      if (wr_undervolt_irq_enable) undervolt_irq_enable_q <= reg_wdata[`PRW_CTL_UNDERVOLT_IRQ_ENABLE];
      if (wr_pf)   pf_q   <= reg_wdata[`PRW_CTL_PF_HI:`PRW_CTL_PF_LO];
      if (wr_om)   om_q   <= reg_wdata[`PRW_CTL_OM_HI:`PRW_CTL_OM_LO];
    end
  end

  // ========================================================
  // outputs
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      srst_cnt_q            <= 2'h0;
      reg_rdata_q           <= 16'h0000;
      prescale_factor_q     <= 4'h1;
      op_mode_q             <= PRW_MODE_NORMAL;
      high_temp_interrupt_q <= 1'b0;
      undervolt_interrupt_q <= 1'b0;
      temp_irq_clear_q      <= 1'b0;
      undervolt_irq_clear_q <= 1'b0;
      die_reset_q           <= 1'b0;
      ext_reset_n_q         <= 1'b1;
    end else begin
      srst_cnt_q            <= srst_cnt_d;
      reg_rdata_q           <= reg_rd ? rd_mux : 16'h0000;
      prescale_factor_q     <= pf_decode(pf_q);
      op_mode_q             <= mode_decode(om_q, crank_enable);
      high_temp_interrupt_q <= sr_q[`PRW_SR_HTF] & ~tie_q;
      undervolt_interrupt_q <= sr_q[`PRW_SR_UVF] & ~undervolt_irq_enable_q;
      temp_irq_clear_q      <= temp_clr;
      undervolt_irq_clear_q <= uv_clr;
      die_reset_q           <= srst_cnt_d != 2'h0;
      ext_reset_n_q         <= srst_cnt_d == 2'h0;
    end
  end

  // ========================================================
  // assertions
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);

  sequence s_srst_pulse;
    die_reset_q & ~ext_reset_n_q [*2] ##1 ~die_reset_q;
  endsequence

  a_temp_en_guard: assert property (wr_ctl & ~reg_wdata[15] |=>
    $stable(tie_q)) else $error("temp enable changed without mask");
  a_uv_en_guard: assert property (wr_ctl & reg_wdata[14] |=>
    undervolt_irq_enable_q == $past(reg_wdata[6])) else $error("uv enable not taken");
  a_srst_pulse: assert property (srst_go |=> s_srst_pulse)
    else $error("soft reset pulse wrong");
  a_srst_guard: assert property (reg_wr & ~reg_wdata[13] & ~srst_on
    |=> ~die_reset_q) else $error("soft reset without mask");
  a_pf_guard: assert property (wr_ctl & reg_wdata[11:10] != 2'h3 |=>
    $stable(pf_q)) else $error("prescale changed without mask");
  a_mode_guard: assert property (wr_ctl & reg_wdata[9:8] != 2'h3 |=>
    $stable(om_q)) else $error("mode changed without mask");
  a_pf_decode: assert property (##1 prescale_factor_q ==
    (4'h1 << $past(pf_q))) else $error("prescale decode wrong");
  a_crank_map: assert property (om_q == 2'h3 & ~crank_enable |=>
    op_mode_q == PRW_MODE_STOP) else $error("crank fallback wrong");
  a_temp_irq_pol: assert property (sr_q[7] & ~tie_q |=>
    high_temp_interrupt_q) else $error("temp irq polarity");
  a_htf_live: assert property (temp_warning |=> sr_q[7])
    else $error("high temp flag not set");
  a_flag_set_wins: assert property (watchdog_reset_evt |=> sr_q[4])
    else $error("watchdog flag lost");
endmodule : prw_regs

// ==== tb/prw_regs_bench.sv ====
module prw_regs_bench import prw_pkg::*;;
  timeunit 1ns;
  timeprecision 100ps;
  // ==========================================================
  // signals
  logic        core_clk, rst, reg_wr, reg_rd, crank_enable;
  logic        temp_warning, undervolt_warning;
  logic [15:0] reg_addr, reg_wdata, reg_rdata_q;
  logic [5:0]  evt;
  logic [3:0]  prescale_factor_q;
  prw_mode_t   op_mode_q;
  logic        hti_q, uvi_q, tclr_q, uclr_q, die_q, ext_n_q;
  int          err_count, n_compared, n_tclr, n_uclr, n_die, n_ext;
  logic [7:0]  flag_bit [6] = '{8'h80, 8'h10, 8'h08, 8'h0C, 8'h02, 8'h01};
  // ==========================================================
  // design
  prw_regs DUT (
    .core_clk(core_clk), .rst(rst), .reg_addr(reg_addr),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata),
    .reg_rdata_q(reg_rdata_q), .crank_enable(crank_enable),
    .temp_warning(temp_warning), .thermal_shutdown_reset(evt[0]),
    .undervolt_warning(undervolt_warning), .watchdog_reset_evt(evt[1]),
    .high_rail_reset_evt(evt[2]), .low_rail_reset_evt(evt[3]),
    .lifetime_wake_evt(evt[4]), .low_power_wake_evt(evt[5]),
    .prescale_factor_q(prescale_factor_q), .op_mode_q(op_mode_q),
    .high_temp_interrupt_q(hti_q), .undervolt_interrupt_q(uvi_q),
    .temp_irq_clear_q(tclr_q), .undervolt_irq_clear_q(uclr_q),
    .die_reset_q(die_q), .ext_reset_n_q(ext_n_q)
  );
  // ==========================================================
  // clock and pulse counters
  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end
  always @(posedge core_clk) begin
    if (tclr_q === 1'b1) n_tclr++;
    if (uclr_q === 1'b1) n_uclr++;
    if (die_q === 1'b1) n_die++;
    if (ext_n_q === 1'b0) n_ext++;
  end
  // ==========================================================
  // access tasks
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    n_compared++;
    if (seen !== exp) begin
      err_count++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  // whole 16-bit words, reserved bits zero
  task automatic wr(input logic [15:0] a, input logic [15:0] d);
    @(posedge core_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge core_clk);
    reg_wr <= 1'b0;
  endtask : wr
  task automatic rdchk(input logic [15:0] a, input logic [15:0] exp);
    @(posedge core_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    #1;
    check(reg_rdata_q, exp);
  endtask : rdchk
  task automatic idle(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask : idle
  task automatic tally_and_finish;
    $display("compared %0d mismatches %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : tally_and_finish
  // ==========================================================
  // sequence
  initial begin
    rst = 1'b1;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = 16'h0000;
    reg_wdata = 16'h0000;
    crank_enable = 1'b0;
    temp_warning = 1'b0;
    undervolt_warning = 1'b0;
    evt = 6'h00;
    repeat (16) @(posedge core_clk);
    rst <= 1'b0;
    idle(2);
    rdchk(16'h0200, 16'h0000);
    rdchk(16'h0202, 16'h0C00);
    check(16'(prescale_factor_q), 16'h0001);
    check(16'(ext_n_q), 16'h0001);
    rdchk(16'h0210, 16'h0000);
    rdchk(16'h0302, 16'h0C00);
    for (int m = 0; m < 4; m++) begin
      wr(16'h0200, {4'h0, 2'(m), 2'(m), 8'h0A});
      idle(3);
      check(16'(prescale_factor_q), (m == 3) ? 16'h0004 : 16'h0001);
      check(16'(op_mode_q), (m == 3) ? 16'h0002 : 16'h0000);
    end
    for (int c = 0; c < 4; c++) begin
      wr(16'h0300, {8'h0F, 4'h0, 2'(c), 2'(c)});
      idle(3);
      check(16'(prescale_factor_q), 16'h0001 << c);
      check(16'(op_mode_q), (c == 3) ? 16'h0001 : 16'(c));
      rdchk(16'h0200, {12'h000, 2'(c), 2'(c)});
    end
    @(posedge core_clk);
    crank_enable <= 1'b1;
    wr(16'h0200, 16'h0303);
    idle(3);
    check(16'(op_mode_q), 16'h0003);
    @(posedge core_clk);
    temp_warning <= 1'b1;
    undervolt_warning <= 1'b1;
    idle(3);
    check(16'({hti_q, uvi_q}), 16'h0003);
    wr(16'h0200, 16'h00C0);
    idle(3);
    check(16'({hti_q, uvi_q}), 16'h0003);
    wr(16'h0200, 16'h80C0);
    idle(3);
    check(16'({hti_q, uvi_q}), 16'h0001);
    wr(16'h0200, 16'h40C0);
    idle(3);
    check(16'({hti_q, uvi_q}), 16'h0000);
    rdchk(16'h0200, 16'h00CF);
    wr(16'h0202, 16'hC000);
    rdchk(16'h0202, 16'hCC00);
    @(posedge core_clk);
    temp_warning <= 1'b0;
    undervolt_warning <= 1'b0;
    idle(1);
    n_tclr = 0;
    n_uclr = 0;
    wr(16'h0202, 16'hC000);
    rdchk(16'h0202, 16'h0C00);
    check(16'(n_tclr + n_uclr), 16'h0002);
    wr(16'h0202, 16'hFF00);
    for (int i = 0; i < 6; i++) begin
      @(posedge core_clk);
      evt[i] <= 1'b1;
      @(posedge core_clk);
      evt <= 6'h00;
      rdchk(16'h0202, {flag_bit[i], 8'h00});
      wr(16'h0202, 16'hFF00);
      rdchk(16'h0202, 16'h0000);
    end
    @(posedge core_clk);
    evt[4] <= 1'b1;
    reg_wr <= 1'b1;
    reg_addr <= 16'h0202;
    reg_wdata <= 16'h0200;
    @(posedge core_clk);
    evt <= 6'h00;
    reg_wr <= 1'b0;
    rdchk(16'h0202, 16'h0200);
    n_die = 0;
    n_ext = 0;
    wr(16'h0200, 16'h0020);
    idle(4);
    check(16'(n_die), 16'h0000);
    wr(16'h0200, 16'h2020);
    idle(4);
    check(16'(n_die), 16'h0002);
    check(16'(n_ext), 16'h0002);
    rdchk(16'h0200, 16'h0000);
    rdchk(16'h0202, 16'h2200);
    tally_and_finish();
  end
endmodule : prw_regs_bench
